// [core/olsc_params.svh]
// Named offsets, field positions, reset values and timing figures of the
// open-loop start-up settings block. Definitions only; included by bare name.
`ifndef OLSC_PARAMS_SVH
`define OLSC_PARAMS_SVH

// Byte addresses on the register bus.
`define OLSC_ADDR_SETTINGS 8'h84
`define OLSC_ADDR_CTRL 8'h88
`define OLSC_ADDR_STATUS 8'h8C
`define OLSC_ADDR_FREQ 8'h90

// Settings register field positions.
`define OLSC_SRC_BIT 30
`define OLSC_DUTY_HI 29
`define OLSC_DUTY_LO 27
`define OLSC_THR_HI 26
`define OLSC_THR_LO 23
`define OLSC_A1_HI 22
`define OLSC_A1_LO 18
`define OLSC_A2_HI 17
`define OLSC_A2_LO 13
`define OLSC_HOF_HI 12
`define OLSC_HOF_LO 8
`define OLSC_AUTO_BIT 7
`define OLSC_FSEL_BIT 6
`define OLSC_MIN_HI 5
`define OLSC_MIN_LO 2
`define OLSC_WR_MASK 32'hFFFF_FFFC
`define OLSC_SETTINGS_RST 32'h0000_0000
`define OLSC_DUTY_RST 7'h0A

// Control register field positions.
`define OLSC_RUN_BIT 0
`define OLSC_GLIM_HI 7
`define OLSC_GLIM_LO 4
`define OLSC_IRATE_HI 11
`define OLSC_IRATE_LO 8
`define OLSC_CTRL_MASK 32'h0000_0FF1
`define OLSC_CTRL_RST 32'h0000_0000

// Acceleration codes and the no-limit figure.
`define OLSC_NOLIMIT_CODE 5'h1F
`define OLSC_NOLIMIT_MHZ 25'h1F3FC18
`define OLSC_SLOPE_LIMIT 36'h7A110BDC0
`define OLSC_SCALE 11'h3E8

// Ramp update period and clock rate.
`define OLSC_TICK_US 1000
`define OLSC_CLK_MHZ 25
`define OLSC_TICK_CYCLES (`OLSC_TICK_US * `OLSC_CLK_MHZ)

`endif

// [core/olsc_pkg.sv]
// Types shared by the open-loop start-up settings block.
// Assumes the params header supplies all numeric figures.
package olsc_pkg;

   // Phase of the open-loop frequency ramp.
   typedef enum logic {PH_IDLE, PH_RAMP} olsc_phase_t;

   // Acceleration in milli-units (mHz/s or mHz/s2).
   typedef logic [24:0] olsc_accel_t;

   // Ramp slope in uHz/s and frequency in nHz.
   typedef logic [35:0] olsc_slope_t;
   typedef logic [47:0] olsc_freq_t;

endpackage

// [core/olsc_decode.sv]
// Code-to-value decoders for the duty cap and both acceleration fields.
// Purely combinational; the parent registers every result it drives out.
`timescale 1ns/100ps
`include "olsc_params.svh"

module olsc_decode (
   input wire logic [2:0] duty_code,
   input wire logic [4:0] a1_code,
   input wire logic [4:0] a2_code,
   output logic [6:0] duty_pct,
   output olsc_pkg::olsc_accel_t a1_mhz,
   output olsc_pkg::olsc_accel_t a2_mhz
);
   import olsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Both acceleration fields share one table, scaled by a thousand.
   function automatic olsc_accel_t accel_mhz(input logic [4:0] code);
      case (code)
         5'h00: accel_mhz = 25'h0000005;
         5'h01: accel_mhz = 25'h000000A;
         5'h02: accel_mhz = 25'h0000019;
         5'h03: accel_mhz = 25'h0000032;
         5'h04: accel_mhz = 25'h0000064;
         5'h05: accel_mhz = 25'h00000FA;
         5'h06: accel_mhz = 25'h00001F4;
         5'h07: accel_mhz = 25'h00003E8;
         5'h08: accel_mhz = 25'h00009C4;
         5'h09: accel_mhz = 25'h0001388;
         5'h0A: accel_mhz = 25'h0001D4C;
         5'h0B: accel_mhz = 25'h0002710;
         5'h0C: accel_mhz = 25'h00030D4;
         5'h0D: accel_mhz = 25'h0003A98;
         5'h0E: accel_mhz = 25'h0004E20;
         5'h0F: accel_mhz = 25'h0007530;
         5'h10: accel_mhz = 25'h0009C40;
         5'h11: accel_mhz = 25'h000C350;
         5'h12: accel_mhz = 25'h000EA60;
         5'h13: accel_mhz = 25'h00124F8;
         5'h14: accel_mhz = 25'h00186A0;
         5'h15: accel_mhz = 25'h001E848;
         5'h16: accel_mhz = 25'h00249F0;
         5'h17: accel_mhz = 25'h002AB98;
         5'h18: accel_mhz = 25'h0030D40;
         5'h19: accel_mhz = 25'h003D090;
         5'h1A: accel_mhz = 25'h00493E0;
         5'h1B: accel_mhz = 25'h0061A80;
         5'h1C: accel_mhz = 25'h007A120;
         5'h1D: accel_mhz = 25'h00B71B0;
         5'h1E: accel_mhz = 25'h00F4240;
         default: accel_mhz = `OLSC_NOLIMIT_MHZ;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Linear and second-order coefficients.
   always_comb begin
      a1_mhz = accel_mhz(a1_code);
      a2_mhz = accel_mhz(a2_code);
   end

   // Duty cap in whole percent.
   always_comb begin
      case (duty_code)
         3'h0: duty_pct = 7'h0A;
         3'h1: duty_pct = 7'h0F;
         3'h2: duty_pct = 7'h14;
         3'h3: duty_pct = 7'h19;
         3'h4: duty_pct = 7'h1E;
         3'h5: duty_pct = 7'h28;
         3'h6: duty_pct = 7'h32;
         default: duty_pct = 7'h64;
      endcase
   end

endmodule

// [core/olsc_top.sv]
// Open-loop start-up settings register with its ramp generator.
// Assumes a classic Wishbone master on CLK and a sequencer that reads the
// decoded outputs; all inputs come from logic on the same clock.
//
// Notes on behaviour
// - Bit 30 selects the current-limit source; zero uses the open-loop threshold field.
// - Bit 30 set applies the general current limit during open loop instead.
// - Bits 29..27 cap open-loop duty: 10,15,20,25,30,40,50,100 percent.
// - Bits 26..23 give the threshold in 0.1 V steps; code zero is reserved.
// - Bits 22..18 give linear acceleration, 0.005 up to 1000 Hz/s.
// - Linear code 1F means no limit, carried as 32767 Hz/s.
// - Bits 17..13 give second-order acceleration, 0.005 up to 1000 Hz/s2.
// - Second-order code 1F means no limit, carried as 32767 Hz/s2.
// - Handoff uses the threshold field unless auto handoff is set.
// - First-cycle rate comes from its setting, or 0 Hz when select is set.
`timescale 1ns/100ps
`include "olsc_params.svh"

module olsc_top #(
   parameter int TICK_CYCLES = `OLSC_TICK_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] ADR_I,
   input wire logic [31:0] DAT_I,
   input wire logic WE_I,
   input wire logic [3:0] SEL_I,
   input wire logic STB_I,
   input wire logic CYC_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   output logic [6:0] DUTY_CAP_PCT,
   output logic [3:0] CURR_THR_DV,
   output logic CURR_THR_OK,
   output logic RAMP_ACTIVE,
   output olsc_pkg::olsc_slope_t SLOPE_UHZ,
   output olsc_pkg::olsc_freq_t FREQ_NHZ,
   output logic HANDOFF_AUTO,
   output logic [4:0] HANDOFF_CODE,
   output logic FIRST_RATE_ZERO,
   output logic [3:0] FIRST_RATE_CODE,
   output logic [3:0] MIN_DUTY_CODE
);
   import olsc_pkg::*;

   logic ack_q;
   logic [31:0] dat_q;
   logic [31:0] settings_q;
   logic [31:0] ctrl_q;
   logic bus_req;
   logic [31:0] rd_d;
   logic [6:0] duty_pct;
   olsc_accel_t a1_mhz;
   olsc_accel_t a2_mhz;
   olsc_phase_t phase_q;
   logic [31:0] tick_cnt_q;
   logic tick;
   olsc_slope_t slope_q;
   olsc_freq_t freq_q;
   logic [3:0] thr_d;
   logic nolimit;

   ////////////////////////////////////////////////////////////////////////
   // Byte-lane merge for writes; bits outside the mask stay untouched, but the settings mask keeps unused bit 31 writable.
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] sel,
                                         input logic [31:0] mask);
      logic [31:0] lanes;
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
      merge = (old_v & ~lanes) | (new_v & lanes);
   endfunction

   // Scales a milli-unit acceleration up to micro-units.
   function automatic olsc_slope_t to_micro(input olsc_accel_t v);
      to_micro = 36'(v * `OLSC_SCALE);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one request is taken per cycle without ack high, so
   // ack comes one edge after the request and drops on the next edge.
   assign bus_req = CYC_I & STB_I & ~ack_q;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req;
      end
   end

   // Settings register; writes land on the same edge that raises ack.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         settings_q <= `OLSC_SETTINGS_RST;
      end else if (bus_req && WE_I && ADR_I == `OLSC_ADDR_SETTINGS) begin
         settings_q <= merge(settings_q, DAT_I, SEL_I, `OLSC_WR_MASK);
      end
   end

   // Control register: run bit, general current limit, first-cycle rate.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctrl_q <= `OLSC_CTRL_RST;
      end else if (bus_req && WE_I && ADR_I == `OLSC_ADDR_CTRL) begin
         ctrl_q <= merge(ctrl_q, DAT_I, SEL_I, `OLSC_CTRL_MASK);
      end
   end

   // Read mux; unmapped addresses read zero and still acknowledge.
   always_comb begin
      case (ADR_I)
         `OLSC_ADDR_SETTINGS: rd_d = settings_q & `OLSC_WR_MASK;
         `OLSC_ADDR_CTRL: rd_d = ctrl_q;
         `OLSC_ADDR_STATUS: rd_d = {31'h00000000, phase_q == PH_RAMP};
         `OLSC_ADDR_FREQ: rd_d = freq_q[47:16];
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dat_q <= 32'h0000_0000;
      end else if (bus_req && !WE_I) begin
         dat_q <= rd_d;
      end
   end

   assign ACK_O = ack_q;
   assign DAT_O = dat_q;

   ////////////////////////////////////////////////////////////////////////
   // Field decoders.
   olsc_decode u_decode (
      .duty_code(settings_q[`OLSC_DUTY_HI:`OLSC_DUTY_LO]),
      .a1_code(settings_q[`OLSC_A1_HI:`OLSC_A1_LO]),
      .a2_code(settings_q[`OLSC_A2_HI:`OLSC_A2_LO]),
      .duty_pct(duty_pct),
      .a1_mhz(a1_mhz),
      .a2_mhz(a2_mhz)
   );

   // Current threshold source select; code zero is flagged as not usable.
   always_comb begin
      if (settings_q[`OLSC_SRC_BIT]) begin
         thr_d = ctrl_q[`OLSC_GLIM_HI:`OLSC_GLIM_LO];
      end else begin
         thr_d = settings_q[`OLSC_THR_HI:`OLSC_THR_LO];
      end
   end

   // Decoded limits are registered so the sequencer sees glitch-free levels.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         DUTY_CAP_PCT <= `OLSC_DUTY_RST;
         CURR_THR_DV <= 4'h0;
         CURR_THR_OK <= 1'b0;
      end else begin
         DUTY_CAP_PCT <= duty_pct;
         CURR_THR_DV <= thr_d;
         CURR_THR_OK <= (thr_d != 4'h0);
      end
   end

   // Handoff, first-cycle and minimum-duty fields passed to the sequencer.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         HANDOFF_AUTO <= 1'b0;
         HANDOFF_CODE <= 5'h00;
         FIRST_RATE_ZERO <= 1'b0;
         FIRST_RATE_CODE <= 4'h0;
         MIN_DUTY_CODE <= 4'h0;
      end else begin
         HANDOFF_AUTO <= settings_q[`OLSC_AUTO_BIT];
         HANDOFF_CODE <= settings_q[`OLSC_HOF_HI:`OLSC_HOF_LO];
         FIRST_RATE_ZERO <= settings_q[`OLSC_FSEL_BIT];
         FIRST_RATE_CODE <= settings_q[`OLSC_FSEL_BIT] ? 4'h0 :
                            ctrl_q[`OLSC_IRATE_HI:`OLSC_IRATE_LO];
         MIN_DUTY_CODE <= settings_q[`OLSC_MIN_HI:`OLSC_MIN_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ramp phase follows the run bit; clearing it stops and clears the ramp.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         phase_q <= PH_IDLE;
      end else begin
         case (phase_q)
            PH_IDLE: if (ctrl_q[`OLSC_RUN_BIT]) phase_q <= PH_RAMP;
            PH_RAMP: if (!ctrl_q[`OLSC_RUN_BIT]) phase_q <= PH_IDLE;
            default: phase_q <= PH_IDLE;
         endcase
      end
   end

   // Millisecond tick; a parameter so simulation can shorten it.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tick_cnt_q <= 32'h0000_0000;
      end else if (phase_q != PH_RAMP || tick) begin
         tick_cnt_q <= 32'h0000_0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
   end

   assign tick = (phase_q == PH_RAMP) && (tick_cnt_q == 32'(TICK_CYCLES - 1));
   assign nolimit = (settings_q[`OLSC_A1_HI:`OLSC_A1_LO] == `OLSC_NOLIMIT_CODE) ||
                    (settings_q[`OLSC_A2_HI:`OLSC_A2_LO] == `OLSC_NOLIMIT_CODE);

   // Slope in uHz/s: starts at the linear term and gains the second-order
   // term each millisecond, since mHz/s2 over 1 ms is exactly uHz/s.
   // Saturation at the limit keeps a long ramp from wrapping.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         slope_q <= 36'h000000000;
      end else if (phase_q != PH_RAMP) begin
         slope_q <= to_micro(a1_mhz);
      end else if (nolimit) begin
         slope_q <= `OLSC_SLOPE_LIMIT;
      end else if (tick) begin
         if (slope_q + to_micro(25'(a2_mhz)) / `OLSC_SCALE >= `OLSC_SLOPE_LIMIT ||
             slope_q + 36'(a2_mhz) >= `OLSC_SLOPE_LIMIT) begin
            slope_q <= `OLSC_SLOPE_LIMIT;
         end else begin
            slope_q <= slope_q + 36'(a2_mhz);
         end
      end
   end

   // Frequency in nHz: uHz/s over 1 ms adds exactly the slope figure.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         freq_q <= 48'h000000000000;
      end else if (phase_q != PH_RAMP) begin
         freq_q <= 48'h000000000000;
      end else if (tick) begin
         freq_q <= freq_q + 48'(slope_q);
      end
   end

   // Ramp state out to the sequencer.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         RAMP_ACTIVE <= 1'b0;
         SLOPE_UHZ <= 36'h000000000;
         FREQ_NHZ <= 48'h000000000000;
      end else begin
         RAMP_ACTIVE <= (phase_q == PH_RAMP);
         SLOPE_UHZ <= slope_q;
         FREQ_NHZ <= freq_q;
      end
   end

endmodule

// [tb/olsc_props.sv]
// Concurrent checks on the open-loop start-up settings block.
// Bound to olsc_top; sees only its ports, all on CLK.
`timescale 1ns/100ps
`include "olsc_params.svh"
module olsc_props #(
   parameter int TICK_CYCLES = 10
) (
   input logic CLK,
   input logic RST,
   input logic [7:0] ADR_I,
   input logic [31:0] DAT_I,
   input logic WE_I,
   input logic [3:0] SEL_I,
   input logic STB_I,
   input logic CYC_I,
   input logic [31:0] DAT_O,
   input logic ACK_O,
   input logic [6:0] DUTY_CAP_PCT,
   input logic [3:0] CURR_THR_DV,
   input logic CURR_THR_OK,
   input logic RAMP_ACTIVE,
   input olsc_pkg::olsc_slope_t SLOPE_UHZ,
   input logic HANDOFF_AUTO,
   input logic [4:0] HANDOFF_CODE,
   input logic FIRST_RATE_ZERO,
   input logic [3:0] FIRST_RATE_CODE
);
   import olsc_pkg::*;
   // Reset masks every check, so a cycle cut short by reset is not judged.
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////////////////////
   // Duty cap per code; the top code leaves duty unlimited.
   function automatic logic [6:0] duty_of(input logic [2:0] c);
      logic [6:0] t [8];
      t = '{7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1E, 7'h28, 7'h32, 7'h64};
      return t[c];
   endfunction
   // An unanswered request, and an answered full-word settings write.
   sequence s_req;
      CYC_I && STB_I && !ACK_O;
   endsequence
   sequence s_set_wr;
      CYC_I && STB_I && WE_I && ACK_O && ADR_I == `OLSC_ADDR_SETTINGS && SEL_I == 4'hF;
   endsequence
   property p_ack;
      s_req |=> ACK_O ##1 !ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("ack is not one pulse");
   property p_src_zero;
      s_set_wr ##0 !DAT_I[30] |=> CURR_THR_DV == $past(DAT_I[26:23]);
   endproperty
   a_src_zero: assert property (p_src_zero) else $error("threshold source");
   property p_duty;
      s_set_wr |=> DUTY_CAP_PCT == duty_of($past(DAT_I[29:27]));
   endproperty
   a_duty: assert property (p_duty) else $error("duty cap decode");
   property p_thr_ok;
      CURR_THR_OK == (CURR_THR_DV != 4'h0);
   endproperty
   a_thr_ok: assert property (p_thr_ok) else $error("threshold valid flag");
   property p_a1_free;
      s_set_wr ##0 DAT_I[22:18] == 5'h1F |-> ##[1:2] SLOPE_UHZ == `OLSC_SLOPE_LIMIT;
   endproperty
   a_a1_free: assert property (p_a1_free) else $error("linear no-limit slope");
   property p_a2_free;
      s_set_wr ##0 (DAT_I[17:13] == 5'h1F && RAMP_ACTIVE) |->
         ##[1:2] SLOPE_UHZ == `OLSC_SLOPE_LIMIT;
   endproperty
   a_a2_free: assert property (p_a2_free) else $error("second-order no-limit");
   property p_handoff;
      s_set_wr |=> HANDOFF_AUTO == $past(DAT_I[7]) && HANDOFF_CODE == $past(DAT_I[12:8]);
   endproperty
   a_handoff: assert property (p_handoff) else $error("handoff fields");
   property p_first_zero;
      s_set_wr ##0 DAT_I[6] |=> FIRST_RATE_ZERO && FIRST_RATE_CODE == 4'h0;
   endproperty
   a_first_zero: assert property (p_first_zero) else $error("first rate zero");
   property p_rsvd_rd;
      CYC_I && !WE_I && ACK_O && ADR_I == `OLSC_ADDR_SETTINGS |-> DAT_O[1:0] == 2'h0;
   endproperty
   a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bits read");
   property p_slope_cap;
      SLOPE_UHZ <= `OLSC_SLOPE_LIMIT;
   endproperty
   a_slope_cap: assert property (p_slope_cap) else $error("slope above limit");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind olsc_top olsc_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.CLK(CLK), .RST(RST),
   .ADR_I(ADR_I), .DAT_I(DAT_I), .WE_I(WE_I), .SEL_I(SEL_I), .STB_I(STB_I), .CYC_I(CYC_I),
   .DAT_O(DAT_O), .ACK_O(ACK_O), .DUTY_CAP_PCT(DUTY_CAP_PCT), .CURR_THR_DV(CURR_THR_DV),
   .CURR_THR_OK(CURR_THR_OK), .RAMP_ACTIVE(RAMP_ACTIVE), .SLOPE_UHZ(SLOPE_UHZ),
   .HANDOFF_AUTO(HANDOFF_AUTO),
   .HANDOFF_CODE(HANDOFF_CODE), .FIRST_RATE_ZERO(FIRST_RATE_ZERO),
   .FIRST_RATE_CODE(FIRST_RATE_CODE));

// [tb/tb_top.sv]
// Self-checking bench for the open-loop start-up settings block.
// Drives olsc_top over classic Wishbone and keeps its own copy of both registers.
`timescale 1ns/100ps
`include "olsc_params.svh"
module tb_top;
   import olsc_pkg::*;
   localparam int TICK = 10;
   localparam logic [35:0] LIM = `OLSC_SLOPE_LIMIT;
   logic clk, rst, we, stb, cyc, ack, thr_ok, ramp, h_auto, f_zero;
   logic [7:0] adr;
   logic [31:0] dat, dat_o, set_m, ctl_m, q, v;
   logic [3:0] sel, thr, f_code, min_d;
   logic [6:0] duty;
   logic [4:0] h_code;
   olsc_slope_t slope, s0;
   olsc_freq_t freq;
   int mismatches, n_checks, seed, k, n;
   int duty_t[8] = '{10, 15, 20, 25, 30, 40, 50, 100};
   // Rates in milli-units per second; a 1 ms tick turns them into micro-units.
   longint acc_t[31] = '{5, 10, 25, 50, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 12500,
      15000, 20000, 30000, 40000, 50000, 60000, 75000, 100000, 125000, 150000, 175000,
      200000, 250000, 300000, 400000, 500000, 750000, 1000000};

   olsc_top #(.TICK_CYCLES(TICK)) dut_u (.CLK(clk), .RST(rst), .ADR_I(adr), .DAT_I(dat),
      .WE_I(we), .SEL_I(sel), .STB_I(stb), .CYC_I(cyc), .DAT_O(dat_o), .ACK_O(ack),
      .DUTY_CAP_PCT(duty), .CURR_THR_DV(thr), .CURR_THR_OK(thr_ok), .RAMP_ACTIVE(ramp),
      .SLOPE_UHZ(slope), .FREQ_NHZ(freq), .HANDOFF_AUTO(h_auto), .HANDOFF_CODE(h_code),
      .FIRST_RATE_ZERO(f_zero), .FIRST_RATE_CODE(f_code), .MIN_DUTY_CODE(min_d));

   // A 40 ns clock.
   always #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   // Compare and count; a mismatch is reported at once.
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; the wait is bounded so a silent slave cannot hang us.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
         input logic [3:0] s);
      int i;
      {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
      for (i = 0; i < 16 && ack !== 1'b1; i++) begin
         @(posedge clk);
      end
      if (ack !== 1'b1) begin
         chk(ack, 1'b1);
      end
      q = dat_o;
      {cyc, stb} <= 2'h0;
      @(posedge clk);
   endtask
   // Writes update the bench copy lane by lane, reserved bits excluded.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      if (a == `OLSC_ADDR_SETTINGS) set_m = (set_m & ~m) | (d & m & `OLSC_WR_MASK);
      if (a == `OLSC_ADDR_CTRL) ctl_m = (ctl_m & ~m) | (d & m & `OLSC_CTRL_MASK);
      bus(a, 1'b1, d, s);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0000_0000, 4'hF);
      chk(q, e);
   endtask
   // Outputs lag the registers by one edge; they are sampled on a falling edge, away
   // from the edge that launches them, and control returns on a rising edge.
   task automatic chk_out();
      @(posedge clk);
      @(negedge clk);
      chk(duty, duty_t[set_m[29:27]]);
      chk(thr, set_m[30] ? ctl_m[7:4] : set_m[26:23]);
      chk(thr_ok, set_m[30] ? ctl_m[7:4] != 0 : set_m[26:23] != 0);
      chk(h_auto, set_m[7]);
      chk(h_code, set_m[12:8]);
      chk(f_zero, set_m[6]);
      chk(f_code, set_m[6] ? 4'h0 : ctl_m[11:8]);
      chk(min_d, set_m[5:2]);
      if (set_m[17:13] != 5'h1F && !ctl_m[0]) begin
         chk(slope, set_m[22:18] == 5'h1F ? LIM : acc_t[set_m[22:18]] * 1000);
      end
      chk(ramp, ctl_m[0]);
      if (!ctl_m[0]) begin
         chk(freq, 48'h0);
      end
      @(posedge clk);
   endtask
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset values, code tables, ramp, random lanes, unmapped place.
   initial begin
      {clk, rst, we, stb, cyc, adr, dat, sel} = 49'h0_8000_0000_0000;
      {mismatches, n_checks, set_m, ctl_m} = 128'h0;
      seed = 95896;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_out();
      rd(`OLSC_ADDR_SETTINGS, 32'h0000_0000);
      wr(`OLSC_ADDR_CTRL, 32'h0000_0A50, 4'hF);
      for (k = 0; k < 32; k++) begin
         v = {k[0], k[4], k[2:0], k[3:0], k[4:0], 5'h00, k[4:0], k[1], k[2], k[3:0], 2'h3};
         wr(`OLSC_ADDR_SETTINGS, v, 4'hF);
         chk_out();
         rd(`OLSC_ADDR_SETTINGS, set_m);
      end
      // Each second-order code: after the first tick the slope grows by that rate; code 1F pins it at the limit.
      for (k = 0; k < 32; k++) begin
         wr(`OLSC_ADDR_SETTINGS, k << 13, 4'hF);
         wr(`OLSC_ADDR_CTRL, 32'h0000_0001, 4'hF);
         // The idle slope is the code-0 linear rate; watch on falling edges for it to move.
         s0 = 36'(acc_t[0] * 1000);
         for (n = 0; n < 3 * TICK && slope === s0; n++) begin
            @(negedge clk);
         end
         chk(ramp, 1'b1);
         chk(slope, k == 31 ? LIM : 5000 + acc_t[k]);
         if (k != 31) begin
            chk(freq, 48'h0000_0000_1388);
         end
         @(posedge clk);
         rd(`OLSC_ADDR_STATUS, 32'h0000_0001);
         // A second-order no-limit code written while the ramp runs must pin the slope.
         if (k == 31) begin
            wr(`OLSC_ADDR_SETTINGS, k << 13, 4'hF);
         end
         wr(`OLSC_ADDR_CTRL, 32'h0000_0000, 4'hF);
         chk_out();
      end
      for (k = 0; k < 24; k++) begin
         wr(`OLSC_ADDR_SETTINGS, $random(seed), 4'($random(seed)));
         wr(`OLSC_ADDR_CTRL, $random(seed) & 32'hFFFF_FFFE, 4'($random(seed)));
         chk_out();
         rd(`OLSC_ADDR_SETTINGS, set_m);
         rd(`OLSC_ADDR_CTRL, ctl_m);
      end
      wr(8'h00, 32'hFFFF_FFFF, 4'hF);
      rd(8'h00, 32'h0000_0000);
      rd(`OLSC_ADDR_SETTINGS, set_m);
      complete_run();
   end
   // Watchdog well above the roughly 1400 cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end
endmodule
